// File: design/uirq_pkg.sv
// Constants and types of the serial port request logic
package uirq_pkg;
  localparam int           NUM_SRC            = 7;
  localparam int           ADDR_W             = 4;
  // Byte offsets on the register bus
  localparam logic [3:0]   OFS_ENABLE_CLEAR   = 4'h0;
  localparam logic [3:0]   OFS_ENABLE_SET     = 4'h4;
  localparam logic [3:0]   OFS_FLAG_STATUS    = 4'h8;
  localparam logic [3:0]   OFS_PRIMARY_CTRL   = 4'hc;
  // Source bit positions
  localparam int           BIT_TX_EMPTY       = 0;
  localparam int           BIT_RX_COMPLETE    = 1;
  localparam int           BIT_TX_COMPLETE    = 2;
  localparam int           BIT_RX_START       = 3;
  localparam int           BIT_CTS_CHANGE     = 4;
  localparam int           BIT_BREAK          = 5;
  localparam int           BIT_ERROR          = 7;
  // Control bit positions
  localparam int           BIT_RUN_STANDBY    = 7;
  localparam int           BIT_INT_CLOCK      = 2;
  localparam logic [7:0]   RST_ENABLE         = 8'h00;
  localparam logic [7:0]   RST_FLAGS          = 8'h00;
  localparam logic [7:0]   RST_CTRL           = 8'h00;
  localparam logic [7:0]   SRC_MASK           = 8'hbf;
  typedef logic [7:0] uirq_byte_t;
endpackage

// File: design/uirq_bus_if.sv
// Decoded register access passed from the bus slave to the request core
`timescale 1ns/1ps
`default_nettype none
interface uirq_bus_if;
  logic                 wr_stb;
  logic                 rd_stb;
  logic [3:0]           addr;
  logic [7:0]           wdata;
  logic [7:0]           rdata;
  modport slave  (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport core   (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: design/uirq_wb_slave.sv
// Classic Wishbone slave producing one-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module uirq_wb_slave
  import uirq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [0:0]  sel_i,
  input  wire logic [7:0]  dat_i,
  output logic      [7:0]  dat_o,
  output logic             ack_o,
  // Decoded access
  uirq_bus_if.slave        bus
);
  import uirq_pkg::*;

  logic req;

  // Ack after one wait cycle, never two in a row
  assign req        = cyc_i && stb_i && !ack_o;
  // Writes land on the ack edge, so an abandoned cycle changes nothing
  assign bus.wr_stb = cyc_i && stb_i && ack_o && we_i && sel_i[0];
  assign bus.rd_stb = req && !we_i;
  assign bus.addr   = adr_i;
  assign bus.wdata  = dat_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 8'h00;
    end else if (bus.rd_stb) begin
      dat_o <= bus.rdata;
    end
  end
endmodule // uirq_wb_slave
`default_nettype wire

// File: design/uirq_top.sv
// Serial port DMA and interrupt request logic
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module uirq_top
  import uirq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone register bus
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [0:0]  sel_i,
  input  wire logic [7:0]  dat_i,
  output logic      [7:0]  dat_o,
  output logic             ack_o,
  // Datapath status and events
  input  wire logic        rx_fifo_avail_i,
  input  wire logic        tx_buffer_empty_i,
  input  wire logic        data_read_i,
  input  wire logic        data_write_i,
  input  wire logic        receive_complete_i,
  input  wire logic        transmit_complete_i,
  input  wire logic        receive_start_i,
  input  wire logic        clear_to_send_change_i,
  input  wire logic        break_received_i,
  input  wire logic        error_i,
  // Sleep
  input  wire logic        sleep_i,
  // Requests
  output logic             rx_dma_req_o,
  output logic             tx_dma_req_o,
  output logic             irq_o,
  output logic             core_clk_req_o
);
  import uirq_pkg::*;

  uirq_bus_if bus ();

  uirq_byte_t irq_flag_status;
  uirq_byte_t irq_enable;
  uirq_byte_t primary_control;
  uirq_byte_t events;
  uirq_byte_t next_flags;
  logic       rx_hold;
  logic       tx_hold;
  logic       wr_en_set;
  logic       wr_en_clr;
  logic       wr_flag;
  logic       wr_ctrl;

  uirq_wb_slave u_slave (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (cyc_i),
    .stb_i (stb_i),
    .we_i  (we_i),
    .adr_i (adr_i),
    .sel_i (sel_i),
    .dat_i (dat_i),
    .dat_o (dat_o),
    .ack_o (ack_o),
    .bus   (bus)
  );

  assign wr_en_set = bus.wr_stb && (bus.addr == OFS_ENABLE_SET);
  assign wr_en_clr = bus.wr_stb && (bus.addr == OFS_ENABLE_CLEAR);
  assign wr_flag   = bus.wr_stb && (bus.addr == OFS_FLAG_STATUS);
  assign wr_ctrl   = bus.wr_stb && (bus.addr == OFS_PRIMARY_CTRL);

  // Source conditions; bit 6 unused in the layout
  always_comb begin
    events                  = 8'h00;
    events[BIT_TX_EMPTY]    = tx_buffer_empty_i;
    events[BIT_RX_COMPLETE] = receive_complete_i;
    events[BIT_TX_COMPLETE] = transmit_complete_i;
    events[BIT_RX_START]    = receive_start_i;
    events[BIT_CTS_CHANGE]  = clear_to_send_change_i;
    events[BIT_BREAK]       = break_received_i;
    events[BIT_ERROR]       = error_i;
  end

  // Set wins over a simultaneous write-one clear
  always_comb begin
    next_flags = irq_flag_status;
    if (wr_flag) begin
      next_flags = next_flags & ~bus.wdata;
    end
    next_flags = (next_flags | events) & SRC_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_flag_status <= RST_FLAGS;
    end else begin
      irq_flag_status <= next_flags;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable <= RST_ENABLE;
    end else if (wr_en_set) begin
      irq_enable <= (irq_enable | bus.wdata) & SRC_MASK;
    end else if (wr_en_clr) begin
      irq_enable <= irq_enable & ~bus.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_control <= RST_CTRL;
    end else if (wr_ctrl) begin
      primary_control <= bus.wdata;
    end
  end

  // Register read mux
  always_comb begin
    case (bus.addr)
      OFS_ENABLE_SET:   bus.rdata = irq_enable;
      OFS_ENABLE_CLEAR: bus.rdata = irq_enable;
      OFS_FLAG_STATUS:  bus.rdata = irq_flag_status;
      OFS_PRIMARY_CTRL: bus.rdata = primary_control;
      default:          bus.rdata = 8'h00;
    endcase
  end

  // Interrupt from next state so it follows flags with no extra lag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (wr_en_set) begin
      irq_o <= |(next_flags & (irq_enable | bus.wdata));
    end else if (wr_en_clr) begin
      irq_o <= |(next_flags & irq_enable & ~bus.wdata);
    end else begin
      irq_o <= |(next_flags & irq_enable);
    end
  end

  // A read or a write drops its request for one cycle, then occupancy decides
  assign rx_hold = data_read_i;
  assign tx_hold = data_write_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_dma_req_o <= 1'b0;
    end else begin
      rx_dma_req_o <= rx_fifo_avail_i && !rx_hold;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_dma_req_o <= 1'b0;
    end else begin
      tx_dma_req_o <= tx_buffer_empty_i && !tx_hold;
    end
  end

  // Core clock kept while asleep only when running on it in standby
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_clk_req_o <= 1'b1;
    end else begin
      core_clk_req_o <= !sleep_i ||
                        (primary_control[BIT_RUN_STANDBY] && primary_control[BIT_INT_CLOCK]);
    end
  end
endmodule // uirq_top
`default_nettype wire

// File: tb/uirq_checker.sv
// Port assertions for the request logic
`timescale 1ns/1ps
`default_nettype none
module uirq_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [0:0] sel_i,
  input wire logic [7:0] dat_i,
  input wire logic ack_o,
  input wire logic irq_o,
  input wire logic rx_fifo_avail_i,
  input wire logic tx_buffer_empty_i,
  input wire logic data_read_i,
  input wire logic data_write_i,
  input wire logic sleep_i,
  input wire logic rx_dma_req_o,
  input wire logic tx_dma_req_o,
  input wire logic core_clk_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic tk = cyc_i && stb_i && we_i && ack_o;
  rx_req_a: assert property (rx_fifo_avail_i && !data_read_i |=> rx_dma_req_o)
    else $error("rx request missing");
  rx_drop_a: assert property (data_read_i |=> !rx_dma_req_o)
    else $error("rx request kept");
  tx_req_a: assert property (tx_buffer_empty_i && !data_write_i |=> tx_dma_req_o)
    else $error("tx request missing");
  tx_drop_a: assert property (data_write_i |=> !tx_dma_req_o)
    else $error("tx request kept");
  bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bad ack");
  irq_off_a: assert property (tk && sel_i[0] && adr_i == 4'h0 && dat_i == 8'hff |=> !irq_o [*2])
    else $error("irq kept after disable");
  irq_hold_a: assert property (irq_o && !tk |=> irq_o)
    else $error("irq dropped");
  clk_wake_a: assert property (!sleep_i |=> core_clk_req_o)
    else $error("clock request low");
endmodule // uirq_checker
bind uirq_top uirq_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .irq_o,
  .rx_fifo_avail_i, .tx_buffer_empty_i, .data_read_i, .data_write_i, .sleep_i, .rx_dma_req_o, .tx_dma_req_o,
  .core_clk_req_o);
`default_nettype wire

// File: tb/uirq_dma_model.sv
// DMA controller model answering the data requests
`timescale 1ns/1ps
`default_nettype none
module uirq_dma_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic rx_req_i,
  input wire logic tx_req_i,
  output logic rd_o,
  output logic wr_o
);
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
  end
  // Gaps between pulses so the request is seen to fall
  always @(posedge clk_i) begin
    rd_o <= go_i && rx_req_i && !rd_o;
    wr_o <= go_i && tx_req_i && !wr_o;
  end
endmodule // uirq_dma_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the request logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uirq_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, sleep_i = 1'b0, av = 1'b0, go = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [0:0] sel_i = 1'b1;
  logic wsel = 1'b1;
  logic [7:0] dat_i = 8'h00, ev = 8'h00, rd;
  wire logic [7:0] dat_o;
  wire logic ack_o, rxq, txq, irq_o, ckq, drd, dwr;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  always #50 clk_i = ~clk_i;
  uirq_top u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .rx_fifo_avail_i(av), .tx_buffer_empty_i(ev[0]), .data_read_i(drd), .data_write_i(dwr),
    .receive_complete_i(ev[1]), .transmit_complete_i(ev[2]), .receive_start_i(ev[3]),
    .clear_to_send_change_i(ev[4]), .break_received_i(ev[5]), .error_i(ev[7]), .sleep_i,
    .rx_dma_req_o(rxq), .tx_dma_req_o(txq), .irq_o, .core_clk_req_o(ckq));
  uirq_dma_model u_dma (.clk_i, .go_i(go), .rx_req_i(rxq), .tx_req_i(txq), .rd_o(drd), .wr_o(dwr));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= wsel;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) mismatches++;
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic t_dma;
    av <= 1'b1;
    ev[0] <= 1'b1;
    tick(3);
    chk(rxq, 1'b1);
    chk(txq, 1'b1);
    go <= 1'b1;
    tick(3);
    chk(rxq, 1'b0);
    chk(txq, 1'b0);
    go <= 1'b0;
    av <= 1'b0;
    ev[0] <= 1'b0;
    tick(3);
    chk({rxq, txq}, 2'b00);
  endtask
  task automatic t_irq;
    logic [7:0] b;
    wb(1'b1, 4'h8, 8'hff);
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      if (SRC_MASK[i]) begin
        ev <= b;
        tick(1);
        ev <= 8'h00;
        tick(2);
        chk(irq_o, 1'b0);
        wb(1'b0, 4'h8, 8'h00);
        chk(rd, b);
        wb(1'b1, 4'h4, b);
        tick(2);
        chk(irq_o, 1'b1);
        wb(1'b0, 4'h0, 8'h00);
        chk(rd, b);
        wb(1'b1, 4'h0, 8'hff);
        tick(1);
        chk(irq_o, 1'b0);
        wb(1'b1, 4'h4, 8'h00);
        wb(1'b0, 4'h4, 8'h00);
        chk(rd, 8'h00);
        wb(1'b1, 4'h4, b);
        tick(2);
        chk(irq_o, 1'b1);
        wb(1'b1, 4'h8, b);
        tick(1);
        chk(irq_o, 1'b0);
        wb(1'b1, 4'h0, b);
      end
    end
    wb(1'b1, 4'h4, 8'hff);
    wb(1'b1, 4'h0, 8'h00);
    wb(1'b0, 4'h0, 8'h00);
    chk(rd, SRC_MASK);
    ev <= 8'h82;
    tick(1);
    ev <= 8'h00;
    wb(1'b1, 4'h8, 8'h02);
    wb(1'b0, 4'h8, 8'h00);
    chk(rd, 8'h80);
    // Mid-run reset must drop the pending request
    rst_i <= 1'b1;
    tick(2);
    chk(irq_o, 1'b0);
    rst_i <= 1'b0;
  endtask
  task automatic t_sleep;
    sleep_i <= 1'b1;
    tick(3);
    chk(ckq, 1'b0);
    wb(1'b1, 4'hc, 8'h84);
    tick(2);
    chk(ckq, 1'b1);
    wsel = 1'b0;
    wb(1'b1, 4'hc, 8'h00);
    wsel = 1'b1;
    wb(1'b1, 4'h2, 8'hff);
    wb(1'b0, 4'h2, 8'h00);
    chk(rd, 8'h00);
    wb(1'b0, 4'hc, 8'h00);
    chk(rd, 8'h84);
    sleep_i <= 1'b0;
  endtask
  initial begin
    tick(2);
    rst_i <= 1'b0;
    wb(1'b0, 4'h4, 8'h00);
    chk(rd, RST_ENABLE);
    chk(ckq, 1'b1);
    t_dma();
    t_irq();
    t_sleep();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
